// *** inc/wdt_guard_pkg.sv ***
// shared constants and types for the watchdog configuration guard
package wdt_guard_pkg;

  // register map: a single control register
  localparam int              ADDR_W        = 2;
  localparam logic [1:0]      CTRL_OFFSET   = 2'h0;
  localparam int              DATA_W        = 8;

  // control register field positions
  localparam int              UNLOCK_BIT    = 4;
  localparam int              ON_BIT        = 3;
  localparam int              SEL_HI        = 2;
  localparam int              SEL_LO        = 0;

  // reset values
  localparam logic [2:0]      SEL_RESET     = 3'h0;
  localparam logic            ON_RESET      = 1'b0;
  localparam logic [7:0]      RDATA_RESET   = 8'h00;

  // unlock window length in system clock cycles
  localparam logic [2:0]      WINDOW_CYCLES = 3'h4;

  // watchdog oscillator counts; code 000 is the base, each step doubles
  localparam int              CNT_W         = 22;
  localparam logic [21:0]     TIMEOUT_BASE  = 22'h004000;

  // fuse levels as seen on the pins: programmed fuse reads zero
  localparam logic            FUSE_PROGRAMMED   = 1'b0;
  localparam logic            FUSE_UNPROGRAMMED = 1'b1;

  // safety levels
  typedef enum logic [1:0] {
    LEVEL0 = 2'b00,
    LEVEL1 = 2'b01,
    LEVEL2 = 2'b10
  } safety_level_t;

  localparam safety_level_t   LEVEL_RESET   = LEVEL1;

  // register bus request travelling as one bundle
  typedef struct packed {
    logic               wr;
    logic               rd;
    logic [ADDR_W-1:0]  addr;
    logic [DATA_W-1:0]  wdata;
  } bus_req_t;

  // control register fields as software sees them
  typedef struct packed {
    logic [2:0]         reserved;
    logic               unlock;
    logic               on;
    logic [2:0]         sel;
  } ctrl_t;

endpackage

// *** src/watchdog_config_guard.sv ***
// watchdog control register with fuse-selected safety levels and counter
//
// Functional notes
// - unlock bit self-clears after four cycles
// - writing on bit enables; zero disables conditionally
// - clearing on bit ignored unless unlocked
// - zero to on within window disables
// - level two never disables the watchdog
// - select code picks doubling oscillator count
// - levels one, two: select changes need window
// - level zero: select writable any time
// - levels zero, one start disabled; enable freely
// - level one second write applies both
// - level two always runs, reads one
// - level two second write applies select only
// - two fuses decode to safety level
// - timeout gives one-cycle reset pulse
// - counter restarts on kick, disable, reset
//
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/10ps

module watchdog_config_guard #(
  parameter logic [21:0] BASE_TICKS = wdt_guard_pkg::TIMEOUT_BASE
) (
  input  wire  logic                  clock,
  input  wire  logic                  rstn,
  input  wire  wdt_guard_pkg::bus_req_t busReq,
  output logic [7:0]                  rdata,
  input  wire  logic                  compatFuseN,
  input  wire  logic                  alwaysOnFuseN,
  input  wire  logic                  wdtOscTick,
  input  wire  logic                  kickInstruction,
  output logic                        wdtResetPulse
);
  import wdt_guard_pkg::*;

  // timeout count for a select code, shortened by BASE_TICKS in simulation
  function automatic logic [CNT_W-1:0] timeoutLimit(input logic [2:0] sel);
    timeoutLimit = BASE_TICKS << sel;
  endfunction

  // fuse pair to safety level
  function automatic safety_level_t decodeLevel(input logic compatN,
                                                input logic alwaysN);
    if (alwaysN == FUSE_PROGRAMMED) begin
      decodeLevel = LEVEL2;
    end else if (compatN == FUSE_PROGRAMMED) begin
      decodeLevel = LEVEL0;
    end else begin
      decodeLevel = LEVEL1;
    end
  endfunction

  // ---------------------------------------------------------------
  // pin synchronisers: fuses and oscillator tick, three stages each
  logic [2:0]     compatSync_q, compatSync_d;
  logic [2:0]     alwaysSync_q, alwaysSync_d;
  logic [2:0]     tickSync_q, tickSync_d;
  logic           compatLvl_q, compatLvl_d;
  logic           alwaysLvl_q, alwaysLvl_d;
  logic           tickLvl_q, tickLvl_d;
  safety_level_t  level_q, level_d;
  logic           tickEdge;

  // a level only counts once stages two and three agree
  always_comb begin
    compatSync_d = {compatSync_q[1:0], compatFuseN};
    alwaysSync_d = {alwaysSync_q[1:0], alwaysOnFuseN};
    tickSync_d   = {tickSync_q[1:0], wdtOscTick};
    compatLvl_d  = compatLvl_q;
    alwaysLvl_d  = alwaysLvl_q;
    tickLvl_d    = tickLvl_q;
    if (compatSync_q[1] == compatSync_q[2]) begin
      compatLvl_d = compatSync_q[2];
    end
    if (alwaysSync_q[1] == alwaysSync_q[2]) begin
      alwaysLvl_d = alwaysSync_q[2];
    end
    if (tickSync_q[1] == tickSync_q[2]) begin
      tickLvl_d = tickSync_q[2];
    end
    level_d  = decodeLevel(compatLvl_q, alwaysLvl_q);
    tickEdge = tickLvl_d & ~tickLvl_q;
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      compatSync_q <= {3{FUSE_UNPROGRAMMED}};
      alwaysSync_q <= {3{FUSE_UNPROGRAMMED}};
      tickSync_q   <= 3'h0;
      compatLvl_q  <= FUSE_UNPROGRAMMED;
      alwaysLvl_q  <= FUSE_UNPROGRAMMED;
      tickLvl_q    <= 1'b0;
      level_q      <= LEVEL_RESET;
    end else begin
      compatSync_q <= compatSync_d;
      alwaysSync_q <= alwaysSync_d;
      tickSync_q   <= tickSync_d;
      compatLvl_q  <= compatLvl_d;
      alwaysLvl_q  <= alwaysLvl_d;
      tickLvl_q    <= tickLvl_d;
      level_q      <= level_d;
    end
  end

  // ---------------------------------------------------------------
  // control register and unlock window
  logic [2:0]  windowCnt_q, windowCnt_d;
  logic        on_q, on_d;
  logic [2:0]  sel_q, sel_d;
  ctrl_t       wr;
  logic        ctrlWrite;
  logic        windowOpen;
  logic        openWrite;
  logic        effOn;

  always_comb begin
    wr          = ctrl_t'(busReq.wdata);
    ctrlWrite   = busReq.wr && (busReq.addr == CTRL_OFFSET);
    windowOpen  = (windowCnt_q != 3'h0);
    openWrite   = ctrlWrite && wr.unlock && wr.on;
    windowCnt_d = windowCnt_q;
    on_d        = on_q;
    sel_d       = sel_q;
    // count down; the unlock bit drops by itself after four cycles
    if (windowOpen) begin
      windowCnt_d = windowCnt_q - 3'h1;
    end
    if (openWrite) begin
      // opening write: on bit written one, so it always enables
      windowCnt_d = WINDOW_CYCLES;
      on_d        = 1'b1;
      if (level_q == LEVEL0) begin
        sel_d = wr.sel;
      end
    end else if (ctrlWrite) begin
      if (wr.on) begin
        on_d = 1'b1;
      end else if (windowOpen && level_q != LEVEL2) begin
        on_d = 1'b0;
      end
      if (level_q == LEVEL0 || windowOpen) begin
        sel_d = wr.sel;
      end
      // the second write of a sequence consumes the window
      if (windowOpen && !wr.unlock) begin
        windowCnt_d = 3'h0;
      end
    end
    effOn = on_q || (level_q == LEVEL2);
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      windowCnt_q <= 3'h0;
      on_q        <= ON_RESET;
      sel_q       <= SEL_RESET;
    end else begin
      windowCnt_q <= windowCnt_d;
      on_q        <= on_d;
      sel_q       <= sel_d;
    end
  end

  // ---------------------------------------------------------------
  // watchdog counter over oscillator ticks
  logic [CNT_W-1:0] count_q, count_d;
  logic             resetPulse_q, resetPulse_d;

  // a kick or a disabled watchdog holds the count at zero
  always_comb begin
    count_d      = count_q;
    resetPulse_d = 1'b0;
    if (kickInstruction || !effOn) begin
      count_d = '0;
    end else if (tickEdge) begin
      if (count_q >= timeoutLimit(sel_q) - 22'h1) begin
        count_d      = '0;
        resetPulse_d = 1'b1;
      end else begin
        count_d = count_q + 22'h1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      count_q      <= '0;
      resetPulse_q <= 1'b0;
    end else begin
      count_q      <= count_d;
      resetPulse_q <= resetPulse_d;
    end
  end

  assign wdtResetPulse = resetPulse_q;

  // ---------------------------------------------------------------
  // read port: data in the cycle after the strobe, zero otherwise
  logic [7:0] rdata_q, rdata_d;
  ctrl_t      rview;

  always_comb begin
    rview          = '0; // reserved bits read as zero
    rview.unlock   = windowOpen;
    rview.on       = effOn;
    rview.sel      = sel_q;
    rdata_d        = RDATA_RESET;
    if (busReq.rd && busReq.addr == CTRL_OFFSET) begin
      rdata_d = rview;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      rdata_q <= RDATA_RESET;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata = rdata_q;

  // ---------------------------------------------------------------
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  // a closing write in the first window cycle ends the count early
  chk_window_opens: assert property (
    openWrite |=> windowCnt_q == WINDOW_CYCLES)
    else $error("unlock window did not open for four cycles");

  chk_window_counts: assert property (
    (windowOpen && !ctrlWrite) |=> windowCnt_q == $past(windowCnt_q) - 3'h1)
    else $error("unlock window did not count down");

  chk_window_closes: assert property (
    (windowCnt_q == 3'h1 && !openWrite) |=> windowCnt_q == 3'h0)
    else $error("unlock bit did not self-clear");

  chk_plain_enable: assert property (
    (ctrlWrite && wr.on) |=> on_q)
    else $error("write of one did not enable watchdog");

  chk_locked_clear: assert property (
    (ctrlWrite && !wr.on && !windowOpen && on_q) |=> on_q)
    else $error("watchdog cleared without unlock");

  chk_timed_disable: assert property (
    (ctrlWrite && !wr.on && windowOpen && level_q != LEVEL2)
      |=> !on_q && !effOn)
    else $error("timed sequence did not disable watchdog");

  // the counter must advance at level two whatever the stored on bit
  chk_level2_runs: assert property (
    (level_q == LEVEL2 && !kickInstruction && tickEdge
      && count_q < timeoutLimit(sel_q) - 22'h1)
      |=> count_q == $past(count_q) + 22'h1)
    else $error("level two watchdog not running");

  chk_level2_reads: assert property (
    (busReq.rd && busReq.addr == CTRL_OFFSET && level_q == LEVEL2)
      |=> rdata[ON_BIT])
    else $error("level two on bit read as zero");

  chk_sel_locked: assert property (
    (ctrlWrite && level_q != LEVEL0 && !windowOpen) |=> $stable(sel_q))
    else $error("select changed without unlock");

  chk_sel_free: assert property (
    (ctrlWrite && level_q == LEVEL0) |=> sel_q == $past(wr.sel))
    else $error("level zero select not applied");

  chk_level1_apply: assert property (
    (ctrlWrite && windowOpen && !wr.unlock && level_q == LEVEL1)
      |=> sel_q == $past(wr.sel) && on_q == $past(wr.on))
    else $error("level one second write not applied");

  chk_level2_sel: assert property (
    (ctrlWrite && windowOpen && !wr.unlock && level_q == LEVEL2)
      |=> sel_q == $past(wr.sel) && effOn)
    else $error("level two second write mishandled");

  chk_start_off: assert property (
    !$past(rstn) |-> !on_q && sel_q == SEL_RESET)
    else $error("watchdog not disabled after reset");

  chk_fuse_level: assert property (
    ##1 level_q == decodeLevel($past(compatLvl_q), $past(alwaysLvl_q)))
    else $error("safety level does not follow fuses");

  chk_timeout_pulse: assert property (
    (effOn && !kickInstruction && tickEdge
      && count_q == timeoutLimit(sel_q) - 22'h1)
      |=> wdtResetPulse ##1 !wdtResetPulse)
    else $error("missing reset pulse at timeout");

  chk_pulse_cause: assert property (
    wdtResetPulse |-> $past(count_q) == timeoutLimit($past(sel_q)) - 22'h1)
    else $error("reset pulse without timeout");

  chk_kick_restart: assert property (
    (kickInstruction || !effOn) |=> count_q == '0 && !wdtResetPulse)
    else $error("counter not restarted");

endmodule // watchdog_config_guard

// *** verif/watchdog_config_guard_tb.sv ***
// self-checking testbench for the watchdog configuration guard
`timescale 1ns/10ps

module watchdog_config_guard_tb;
  import wdt_guard_pkg::*;

  logic        clock;
  logic        rstn;
  bus_req_t    busReq;
  logic [7:0]  rdata;
  logic        compatFuseN;
  logic        alwaysOnFuseN;
  logic        wdtOscTick;
  logic        kickInstruction;
  logic        wdtResetPulse;
  logic        rdSeen;
  logic [7:0]  expQ[$];
  logic [2:0]  rs;
  int          badCount;
  int          nChecks;
  int          pulseCnt;
  int          p;

  // short base count keeps the tested select codes 0 to 2 within a few hundred cycles
  watchdog_config_guard #(.BASE_TICKS(22'h000004)) watchdog_config_guard_inst (
    .clock           (clock),
    .rstn            (rstn),
    .busReq          (busReq),
    .rdata           (rdata),
    .compatFuseN     (compatFuseN),
    .alwaysOnFuseN   (alwaysOnFuseN),
    .wdtOscTick      (wdtOscTick),
    .kickInstruction (kickInstruction),
    .wdtResetPulse   (wdtResetPulse)
  );

  // 125 MHz system clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      badCount++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    $display("checks=%0d mismatches=%0d", nChecks, badCount);
    if (badCount == 0 && nChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // read data stands only in the cycle after the strobe, so sample mid-cycle
  always @(posedge clock) rdSeen <= busReq.rd;

  // compare each read against the oldest note, count reset pulses
  always @(negedge clock) begin
    if (rdSeen === 1'b1) begin
      if (expQ.size() == 0) chk(32'h1, 32'h0);
      else chk({24'h0, rdata}, {24'h0, expQ.pop_front()});
    end else if (rstn === 1'b1) begin
      chk({24'h0, rdata}, 32'h0);
    end
    if (wdtResetPulse === 1'b1) pulseCnt++;
  end

  // the write and read tasks launch right after an edge and return at the next one; idl returns after n edges
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    busReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock);
  endtask

  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    expQ.push_back(e);
    busReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock);
  endtask

  task automatic idl(input int n);
    busReq <= '0;
    repeat (n) @(posedge clock);
  endtask

  // ticks held five clocks each phase so the synchroniser sees every edge
  task automatic ticks(input int n);
    repeat (n) begin
      wdtOscTick <= 1'b1;
      repeat (5) @(posedge clock);
      wdtOscTick <= 1'b0;
      repeat (5) @(posedge clock);
    end
  endtask

  task automatic kick;
    kickInstruction <= 1'b1;
    @(posedge clock);
    kickInstruction <= 1'b0;
    @(posedge clock);
  endtask

  // fuses are set while reset holds and pass the synchronisers after it, so each level gets a fresh reset
  task automatic rst(input logic c, input logic a);
    rstn          <= 1'b0;
    compatFuseN   <= c;
    alwaysOnFuseN <= a;
    busReq        <= '0;
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    repeat (6) @(posedge clock);
  endtask

  // hang guard
  initial begin
    repeat (100000) @(posedge clock);
    badCount++;
    summarize();
  end

  // main sequence
  initial begin
    rstn = 1'b0;
    busReq = '0;
    compatFuseN = 1'b1;
    alwaysOnFuseN = 1'b1;
    wdtOscTick = 1'b0;
    kickInstruction = 1'b0;
    badCount = 0;
    nChecks = 0;
    pulseCnt = 0;
    rs = 3'($urandom(46));
    @(posedge clock);
    for (int i = 0; i < 4; i++) begin
      rst(i[1], i[0]);
      rd(CTRL_OFFSET, i[0] ? 8'h00 : 8'h08);
      idl(1);
    end
    // level 1: disabled watchdog never fires
    rst(1'b1, 1'b1);
    ticks(6);
    chk(pulseCnt, 0);
    wr(2'h1, 8'h0F);
    rd(2'h1, 8'h00);
    wr(CTRL_OFFSET, 8'h0B);
    rd(CTRL_OFFSET, 8'h08);
    wr(CTRL_OFFSET, 8'h00);
    rd(CTRL_OFFSET, 8'h08);
    wr(CTRL_OFFSET, 8'h18);
    rd(CTRL_OFFSET, 8'h18);
    wr(CTRL_OFFSET, 8'h02);
    rd(CTRL_OFFSET, 8'h02);
    wr(CTRL_OFFSET, 8'h0A);
    wr(CTRL_OFFSET, 8'h18);
    idl(3);
    wr(CTRL_OFFSET, 8'h00);
    rd(CTRL_OFFSET, 8'h00);
    wr(CTRL_OFFSET, 8'h08);
    wr(CTRL_OFFSET, 8'h18);
    idl(4);
    rd(CTRL_OFFSET, 8'h08);
    wr(CTRL_OFFSET, 8'h00);
    rd(CTRL_OFFSET, 8'h08);
    // timeout length per select code, kick restarts the count
    for (int s = 0; s < 3; s++) begin
      wr(CTRL_OFFSET, 8'h18);
      wr(CTRL_OFFSET, 8'h08 | 8'(s));
      idl(1);
      kick();
      p = pulseCnt;
      ticks((4 << s) - 1);
      chk(pulseCnt, p);
      kick();
      ticks((4 << s) - 1);
      chk(pulseCnt, p);
      ticks(1);
      chk(pulseCnt, p + 1);
    end
    // level 2: always on, select via timed sequence only
    rst(1'b1, 1'b0);
    p = pulseCnt;
    ticks(4);
    chk(pulseCnt, p + 1);
    wr(CTRL_OFFSET, 8'h00);
    rd(CTRL_OFFSET, 8'h08);
    wr(CTRL_OFFSET, 8'h03);
    rd(CTRL_OFFSET, 8'h08);
    wr(CTRL_OFFSET, 8'h18);
    wr(CTRL_OFFSET, 8'h01);
    rd(CTRL_OFFSET, 8'h09);
    idl(1);
    kick();
    p = pulseCnt;
    ticks(8);
    chk(pulseCnt, p + 1);
    // level 0: select free, disable still timed
    rst(1'b0, 1'b1);
    repeat (4) begin
      rs = 3'($urandom);
      wr(CTRL_OFFSET, {5'h00, rs});
      rd(CTRL_OFFSET, {5'h00, rs});
    end
    wr(CTRL_OFFSET, 8'h0D);
    rd(CTRL_OFFSET, 8'h0D);
    wr(CTRL_OFFSET, 8'h00);
    rd(CTRL_OFFSET, 8'h08);
    wr(CTRL_OFFSET, 8'h18);
    wr(CTRL_OFFSET, 8'h00);
    rd(CTRL_OFFSET, 8'h00);
    idl(2);
    summarize();
  end

endmodule // watchdog_config_guard_tb
